/* logic/aisc_scan_config.sv */
// Control registers and autoscan sequencer of a four-input converter.
// Assumes a host that writes only defined channel configurations, and a
// FIFO outside that reports its fill level and overflows.
`timescale 1ns/1ps

module aisc_scan_config
  import aisc_pkg::*;
(
  input  wire logic                        clk,                    // 25 MHz clock
  input  wire logic                        sys_rst,                // Sync reset, high
  input  wire logic [aisc_pkg::AISC_ADDR_W-1:0] reg_addr,          // Register address
  input  wire logic [aisc_pkg::AISC_DATA_W-1:0] reg_wdata,         // Write data
  input  wire logic                        reg_wr,                 // Write strobe
  input  wire logic                        reg_rd,                 // Read strobe
  output logic [aisc_pkg::AISC_DATA_W-1:0] reg_rdata,              // Read data, next cycle
  input  wire logic                        conv_step,              // One conversion done
  input  wire logic                        fill_reached,           // FIFO at fill level
  input  wire logic                        fifo_overrun,           // FIFO overflow event
  output logic                             cur_differential,       // Current slot is a pair
  output logic [1:0]                       cur_index,              // Current input or pair
  output logic [2:0]                       chan_count,             // Channels per scan
  output logic [1:0]                       selfcheck_sel,          // Test output select
  output logic                             sample_ready_signal,    // Data available
  output logic                             fifo_flush,             // FIFO reset pulse
  output logic                             soft_reset,             // Device reset pulse
  output logic                             ref_external,           // External reference
  output logic                             conv_single,            // Single conversion mode
  output logic                             power_down,             // Converter powered down
  output logic [1:0]                       fill_level,             // Fill level select
  output logic                             strobe_style,           // Read/write strobe style
  output logic                             number_format_select,   // 1 binary, 0 twos compl.
  output logic                             offset_cal,             // Offset calibration
  output logic                             config_readback_enable  // Readback mode
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // Input code of a scan slot; reserved codes fall back to A pos
  function automatic logic [2:0] slot_code(input logic [4:0] cfg, input logic [1:0] slot);
    logic [2:0] code;
    code = AISC_IN_A_POS;
    if (!cfg[4] && cfg[3:2] == 2'h0)
    begin
      code = {1'b0, cfg[1:0]};
    end
    else if (!cfg[4] && cfg[3:2] == 2'h1 && !cfg[1])
    begin
      code = cfg[0] ? AISC_IN_PAIR_B : AISC_IN_PAIR_A;
    end
    else
    begin
      unique case (cfg)
        AISC_CFG_SCAN_2SE,
        AISC_CFG_SCAN_3SE,
        AISC_CFG_SCAN_4SE:    code = {1'b0, slot};
        AISC_CFG_SCAN_SE_DB:  code = (slot == 2'h0) ? AISC_IN_A_POS : AISC_IN_PAIR_B;
        AISC_CFG_SCAN_2SE_DB: code = (slot == 2'h2) ? AISC_IN_PAIR_B
                                                   : {1'b0, slot};
        AISC_CFG_SCAN_DA_DB:  code = (slot == 2'h0) ? AISC_IN_PAIR_A : AISC_IN_PAIR_B;
        default:              code = AISC_IN_A_POS;
      endcase
    end
    return code;
  endfunction

  // Channels in one scan; a pair counts as one
  function automatic logic [2:0] cfg_count(input logic [4:0] cfg);
    logic [2:0] n;
    n = 3'h1;
    unique case (cfg)
      AISC_CFG_SCAN_2SE,
      AISC_CFG_SCAN_SE_DB,
      AISC_CFG_SCAN_DA_DB:  n = 3'h2;
      AISC_CFG_SCAN_3SE,
      AISC_CFG_SCAN_2SE_DB: n = 3'h3;
      AISC_CFG_SCAN_4SE:    n = 3'h4;
      default:              n = 3'h1;
    endcase
    return n;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [9:0]  ctrl0_reg;
  logic [9:2]  ctrl1_reg;
  logic        overrun_reg;
  logic [1:0]  slot_reg;
  logic        ready_prev_reg;
  logic [4:0]  cfg;
  logic        wr_c0;
  logic        wr_c1;
  logic        rd_c1;
  logic        soft_hit;
  logic        ready_now;

  assign cfg      = ctrl0_reg[AISC_C0_SCAN:AISC_C0_PICK_LO];
  assign wr_c0    = reg_wr && reg_addr == AISC_ADDR_CTRL0;
  assign wr_c1    = reg_wr && reg_addr == AISC_ADDR_CTRL1;
  assign rd_c1    = reg_rd && reg_addr == AISC_ADDR_CTRL1;
  assign soft_hit = wr_c1 && reg_wdata[AISC_C1_RESET];
  // Test selections hold the ready signal off
  assign ready_now = fill_reached && ctrl0_reg[AISC_C0_SELF_HI:AISC_C0_SELF_LO] == 2'h0;

  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_hit)
      ctrl0_reg <= AISC_CTRL0_RESET[9:0];
    else if (wr_c0)
      ctrl0_reg <= reg_wdata[9:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_hit)
      ctrl1_reg <= AISC_CTRL1_RESET[9:2];
    else if (wr_c1)
      ctrl1_reg <= reg_wdata[9:2];
  end

  // Event beats the read-clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_hit)
      overrun_reg <= 1'b0;
    else if (fifo_overrun)
      overrun_reg <= 1'b1;
    else if (rd_c1)
      overrun_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd && reg_addr == AISC_ADDR_CTRL0)
      reg_rdata <= {2'h0, ctrl0_reg};
    else if (rd_c1)
      reg_rdata <= {AISC_CTRL1_FIXED, ctrl1_reg, overrun_reg, 1'b0};
    else if (reg_rd)
      reg_rdata <= '0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fifo_flush <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      fifo_flush <= wr_c1 && reg_wdata[AISC_C1_OVR_FLUSH];
      soft_reset <= soft_hit;
    end
  end

  // ****************************************
  // Scan sequencer
  // ****************************************
  // Any configuration change restarts the scan at its first input
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_hit || wr_c0)
      slot_reg <= 2'h0;
    else if (conv_step)
      slot_reg <= ({1'b0, slot_reg} + 3'h1 >= cfg_count(cfg)) ? 2'h0
                : slot_reg + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cur_differential <= 1'b0;
      cur_index        <= 2'h0;
      chan_count       <= 3'h1;
    end
    else
    begin
      {cur_differential, cur_index} <= slot_code(cfg, slot_reg);
      chan_count                    <= cfg_count(cfg);
    end
  end

  // ****************************************
  // Sample-ready and field outputs
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ready_prev_reg      <= 1'b0;
      sample_ready_signal <= 1'b0;
    end
    else
    begin
      ready_prev_reg      <= ready_now;
      sample_ready_signal <= ~(ctrl1_reg[AISC_C1_READY_POL] ^
                               (ctrl1_reg[AISC_C1_READY_TYPE] ? (ready_now && !ready_prev_reg)
                                                              : ready_now));
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      selfcheck_sel          <= 2'h0;
      ref_external           <= 1'b0;
      conv_single            <= 1'b0;
      power_down             <= 1'b0;
      fill_level             <= 2'h0;
      strobe_style           <= 1'b0;
      number_format_select   <= 1'b0;
      offset_cal             <= 1'b0;
      config_readback_enable <= 1'b0;
    end
    else
    begin
      selfcheck_sel          <= ctrl0_reg[AISC_C0_SELF_HI:AISC_C0_SELF_LO];
      ref_external           <= ctrl0_reg[AISC_C0_REF_SEL];
      conv_single            <= ctrl0_reg[AISC_C0_CONV_MODE];
      power_down             <= ctrl0_reg[AISC_C0_POWER_DOWN];
      fill_level             <= ctrl1_reg[AISC_C1_FILL_HI:AISC_C1_FILL_LO];
      strobe_style           <= ctrl1_reg[AISC_C1_STROBE];
      number_format_select   <= ctrl1_reg[AISC_C1_FORMAT];
      offset_cal             <= ctrl1_reg[AISC_C1_OFFSET_CAL];
      config_readback_enable <= ctrl1_reg[AISC_C1_READBACK];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence step_last_s;
    conv_step && !wr_c0 && !soft_hit && {1'b0, slot_reg} + 3'h1 == cfg_count(cfg);
  endsequence

  sequence scan4_third_s;
    cfg == AISC_CFG_SCAN_4SE && slot_reg == 2'h2;
  endsequence

  scan_wrap_a: assert property (step_last_s |=> slot_reg == 2'h0)
    else $error("scan slot did not wrap to first input");

  scan_four_a: assert property (scan4_third_s |=> cur_index == 2'h2 && !cur_differential)
    else $error("four input scan third slot not B pos");

  // Reset config is a pair, but outputs hold reset values one edge past release
  pair_count_a: assert property (cfg == AISC_CFG_DIFF_A && !$past(sys_rst)
                                 |=> chan_count == 3'h1 && cur_differential)
    else $error("single pair not counted as one channel");

  single_pick_a: assert property (cfg[4:2] == 3'h0 |=> cur_index == $past(cfg[1:0]) && !cur_differential)
    else $error("single-ended pick decoded wrongly");

  pair_alt_a: assert property (cfg == AISC_CFG_SCAN_DA_DB && slot_reg == 2'h1 && !wr_c0
                               |=> cur_differential && cur_index == 2'h1)
    else $error("second slot of pair scan not pair B");

  ready_test_a: assert property (ctrl0_reg[9:8] != 2'h0 |=>
                                 sample_ready_signal == !$past(ctrl1_reg[AISC_C1_READY_POL]))
    else $error("sample ready active during test selection");

  ovr_setwin_a: assert property (fifo_overrun && rd_c1 && !soft_hit |=> overrun_reg)
    else $error("overflow lost against read clear");

  flush_pulse_a: assert property (wr_c1 && reg_wdata[1] |=> fifo_flush ##1 !fifo_flush || $past(wr_c1))
    else $error("flush pulse wrong");

  soft_rst_a: assert property (soft_hit |=> ctrl0_reg == AISC_CTRL0_RESET[9:0] && soft_reset)
    else $error("soft reset did not restore first register");

  test_out_a: assert property (wr_c0 && !soft_hit |=> ##1 selfcheck_sel == $past(reg_wdata[9:8], 2))
    else $error("test selection not taken from bits 8 and 9");

  sequence mixed_third_s;
    cfg == AISC_CFG_SCAN_2SE_DB && slot_reg == 2'h2;
  endsequence

  mixed_pair_a: assert property (mixed_third_s |=> cur_differential && cur_index == 2'h1)
    else $error("third slot of mixed scan not pair B");

  scan_three_a: assert property (cfg == AISC_CFG_SCAN_3SE && slot_reg == 2'h2
                                 |=> !cur_differential && cur_index == 2'h2)
    else $error("three input scan third slot not B pos");

  mixed_second_a: assert property (cfg == AISC_CFG_SCAN_SE_DB && slot_reg == 2'h1
                                   |=> cur_differential && cur_index == 2'h1)
    else $error("second slot of mixed scan not pair B");

endmodule

/* logic/aisc_pkg.sv */
// Constants for the converter input scan configuration block.
// Assumes a 12-bit register port with two mapped addresses.
package aisc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          AISC_ADDR_W        = 2;
  localparam int          AISC_DATA_W        = 12;
  localparam logic [1:0]  AISC_ADDR_CTRL0    = 2'h0;
  localparam logic [1:0]  AISC_ADDR_CTRL1    = 2'h1;
  localparam logic [11:0] AISC_CTRL0_RESET   = 12'h020;
  localparam logic [11:0] AISC_CTRL1_RESET   = 12'h430;
  localparam logic [1:0]  AISC_CTRL1_FIXED   = 2'h1;

  // ****************************************
  // First control register fields
  // ****************************************
  localparam int AISC_C0_REF_SEL     = 0;
  localparam int AISC_C0_CONV_MODE   = 1;
  localparam int AISC_C0_POWER_DOWN  = 2;
  localparam int AISC_C0_PICK_LO     = 3;
  localparam int AISC_C0_PICK_HI     = 4;
  localparam int AISC_C0_PAIR_LO     = 5;
  localparam int AISC_C0_PAIR_HI     = 6;
  localparam int AISC_C0_SCAN        = 7;
  localparam int AISC_C0_SELF_LO     = 8;
  localparam int AISC_C0_SELF_HI     = 9;

  // ****************************************
  // Second control register fields
  // ****************************************
  localparam int AISC_C1_RESET       = 0;
  localparam int AISC_C1_OVR_FLUSH   = 1;
  localparam int AISC_C1_FILL_LO     = 2;
  localparam int AISC_C1_FILL_HI     = 3;
  localparam int AISC_C1_READY_TYPE  = 4;
  localparam int AISC_C1_READY_POL   = 5;
  localparam int AISC_C1_STROBE      = 6;
  localparam int AISC_C1_FORMAT      = 7;
  localparam int AISC_C1_OFFSET_CAL  = 8;
  localparam int AISC_C1_READBACK    = 9;
  localparam int AISC_C1_FIXED_LO    = 10;
  localparam int AISC_C1_FIXED_HI    = 11;

  // ****************************************
  // Channel configuration codes {scan, pair_hi, pair_lo, pick}
  // ****************************************
  localparam logic [4:0] AISC_CFG_SCAN_2SE   = 5'h11;
  localparam logic [4:0] AISC_CFG_SCAN_3SE   = 5'h12;
  localparam logic [4:0] AISC_CFG_SCAN_4SE   = 5'h13;
  localparam logic [4:0] AISC_CFG_SCAN_SE_DB = 5'h15;
  localparam logic [4:0] AISC_CFG_SCAN_2SE_DB = 5'h16;
  localparam logic [4:0] AISC_CFG_SCAN_DA_DB = 5'h19;
  localparam logic [4:0] AISC_CFG_DIFF_A     = 5'h04;

  // Selected input code {differential, index}
  typedef enum logic [2:0] {
    AISC_IN_A_POS  = 3'b000,
    AISC_IN_A_NEG  = 3'b001,
    AISC_IN_B_POS  = 3'b010,
    AISC_IN_B_NEG  = 3'b011,
    AISC_IN_PAIR_A = 3'b100,
    AISC_IN_PAIR_B = 3'b101
  } aisc_input_e;

endpackage

/* bench/aisc_host_model.sv */
// Host side of the register port: one-cycle write and read strobes.
// Assumes one clock and a slave that answers a read in the next cycle.
`timescale 1ns/1ps

module aisc_host_model
  import aisc_pkg::*;
(
  input  wire logic                             clk,        // Bus clock
  output logic [aisc_pkg::AISC_ADDR_W-1:0]      reg_addr,   // Address
  output logic [aisc_pkg::AISC_DATA_W-1:0]      reg_wdata,  // Write data
  output logic                                  reg_wr,     // Write strobe
  output logic                                  reg_rd,     // Read strobe
  input  wire logic [aisc_pkg::AISC_DATA_W-1:0] reg_rdata   // Read data
);
  initial
  begin
    reg_addr = 2'h0;
    reg_wdata = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Callers hand in only defined channel codes
  task automatic wr(input logic [1:0] a, input logic [11:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released bus shows the inverse, not a stale copy
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [1:0] a, output logic [11:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    q = reg_rdata;
  endtask
endmodule

/* bench/aisc_scan_config_tb.sv */
// Self-checking bench for the input scan configuration block.
// Assumes the host model drives the register port and the bench the rest.
`timescale 1ns/1ps

module aisc_scan_config_tb;
  import aisc_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        conv_step = 1'b0;
  logic        fill_reached = 1'b0;
  logic        fifo_overrun = 1'b0;
  logic [1:0]  reg_addr, cur_index, selfcheck_sel, fill_level;
  logic [11:0] reg_wdata, reg_rdata, rd_q;
  logic [2:0]  chan_count;
  logic        reg_wr, reg_rd, cur_differential, sample_ready_signal, fifo_flush;
  logic        soft_reset, strobe_style, number_format_select, offset_cal;
  logic        config_readback_enable;
  logic        ref_external, conv_single, power_down;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          nf, ns;

  always #20 clk = ~clk;

  aisc_host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  aisc_scan_config DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .conv_step, .fill_reached, .fifo_overrun, .cur_differential,
    .cur_index, .chan_count, .selfcheck_sel, .sample_ready_signal, .fifo_flush,
    .soft_reset, .ref_external, .conv_single, .power_down, .fill_level,
    .strobe_style, .number_format_select, .offset_cal, .config_readback_enable);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_slot(input logic [2:0] e);
    chk("cur_differential", {11'h000, e[2]}, {11'h000, cur_differential});
    chk("cur_index", {10'h000, e[1:0]}, {10'h000, cur_index});
  endtask

  // Output fields trail a register change by one edge
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic step();
    @(posedge clk);
    conv_step <= 1'b1;
    @(posedge clk);
    conv_step <= 1'b0;
    settle();
  endtask

  task automatic count_pulses();
    nf = 0;
    ns = 0;
    repeat (4)
    begin
      #1;
      nf += int'(fifo_flush === 1'b1);
      ns += int'(soft_reset === 1'b1);
      @(posedge clk);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    host.rd(AISC_ADDR_CTRL0, rd_q);
    chk("ctrl0", AISC_CTRL0_RESET, rd_q);
    host.rd(AISC_ADDR_CTRL1, rd_q);
    chk("ctrl1 fixed", 12'h001, {10'h000, rd_q[11:10]});
    chk("ctrl1", AISC_CTRL1_RESET, rd_q);
    host.wr(2'h3, 12'hFFF);
    host.rd(2'h2, rd_q);
    chk("unmapped", 12'h000, rd_q);
    host.rd(AISC_ADDR_CTRL0, rd_q);
    chk("ctrl0 kept", AISC_CTRL0_RESET, rd_q);
    // Low control bits must not leak into the channel choice
    host.wr(AISC_ADDR_CTRL0, 12'h007);
    settle();
    chk("ctrl0 low fields", 12'h007, {9'h000, power_down, conv_single, ref_external});
    chk_slot(3'h0);
    host.rd(AISC_ADDR_CTRL0, rd_q);
    chk("ctrl0 readback", 12'h007, rd_q);
  endtask

  task automatic test_single();
    for (int p = 0; p < 6; p++)
    begin
      host.wr(AISC_ADDR_CTRL0, (p < 4) ? 12'(p * 8) : 12'(12'h020 + (p - 4) * 8));
      settle();
      chk_slot({p >= 4, (p < 4) ? 2'(p) : 2'(p - 4)});
      chk("chan_count", 12'h001, {9'h000, chan_count});
    end
  endtask

  task automatic test_scan();
    logic [4:0]  code [6] = '{AISC_CFG_SCAN_2SE, AISC_CFG_SCAN_3SE, AISC_CFG_SCAN_4SE,
                              AISC_CFG_SCAN_SE_DB, AISC_CFG_SCAN_2SE_DB, AISC_CFG_SCAN_DA_DB};
    int          n [6] = '{2, 3, 4, 2, 3, 2};
    // One 3-bit slot code per group, first slot lowest
    logic [11:0] seq [6] = '{12'h008, 12'h088, 12'h688, 12'h028, 12'h148, 12'h02C};
    for (int c = 0; c < 6; c++)
    begin
      host.wr(AISC_ADDR_CTRL0, {4'h0, code[c], 3'h0});
      settle();
      chk("chan_count", 12'(n[c]), {9'h000, chan_count});
      // One extra step checks the wrap back to the first slot
      for (int s = 0; s <= n[c]; s++)
      begin
        chk_slot(seq[c][3 * (s % n[c]) +: 3]);
        step();
      end
    end
  endtask

  task automatic test_selfcheck();
    host.wr(AISC_ADDR_CTRL1, 12'h420);
    host.wr(AISC_ADDR_CTRL0, 12'h000);
    fill_reached <= 1'b1;
    settle();
    chk("selfcheck_sel", 12'h000, {10'h000, selfcheck_sel});
    chk("ready", 12'h001, {11'h000, sample_ready_signal});
    for (int t = 1; t < 4; t++)
    begin
      host.wr(AISC_ADDR_CTRL0, 12'(t * 256));
      settle();
      chk("selfcheck_sel", 12'(t), {10'h000, selfcheck_sel});
      chk("ready", 12'h000, {11'h000, sample_ready_signal});
    end
    host.wr(AISC_ADDR_CTRL1, 12'h400);
    settle();
    chk("ready low polarity", 12'h001, {11'h000, sample_ready_signal});
    @(posedge clk);
    fill_reached <= 1'b0;
    // Pulse type, active high: one cycle per rise of the fill condition
    host.wr(AISC_ADDR_CTRL0, 12'h000);
    host.wr(AISC_ADDR_CTRL1, 12'h430);
    settle();
    @(posedge clk);
    fill_reached <= 1'b1;
    nf = 0;
    repeat (5)
    begin
      @(posedge clk);
      #1;
      nf += int'(sample_ready_signal === 1'b1);
    end
    chk("ready pulses", 12'h001, 12'(nf));
    @(posedge clk);
    fill_reached <= 1'b0;
  endtask

  task automatic test_ctrl1();
    host.wr(AISC_ADDR_CTRL1, 12'h3CC);
    settle();
    chk("fields", 12'h3CC, {2'h0, config_readback_enable, offset_cal, number_format_select,
        strobe_style, 2'h0, fill_level, 2'h0});
    host.rd(AISC_ADDR_CTRL1, rd_q);
    chk("ctrl1", 12'h7CC, rd_q);
    @(posedge clk);
    fifo_overrun <= 1'b1;
    @(posedge clk);
    fifo_overrun <= 1'b0;
    host.rd(AISC_ADDR_CTRL1, rd_q);
    chk("overflow set", 12'h7CE, rd_q);
    host.rd(AISC_ADDR_CTRL1, rd_q);
    chk("overflow cleared", 12'h7CC, rd_q);
    host.wr(AISC_ADDR_CTRL1, 12'h3CE);
    count_pulses();
    chk("flush pulses", 12'h001, 12'(nf));
    chk("reset pulses", 12'h000, 12'(ns));
    host.wr(AISC_ADDR_CTRL1, 12'h001);
    count_pulses();
    chk("reset pulses", 12'h001, 12'(ns));
    host.rd(AISC_ADDR_CTRL1, rd_q);
    chk("ctrl1 after reset", AISC_CTRL1_RESET, rd_q);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_single();
    test_scan();
    test_selfcheck();
    test_ctrl1();
    final_report();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    #(40 * 4000);
    n_errors++;
    final_report();
  end
endmodule
